// ### rtl/spd_regs.svh
// Purpose: Offsets, field positions and reset values of the serial port pin data block
// Assumes: Word-aligned byte addresses on the plain register port
// Notes: Definitions only
`ifndef SPD_REGS_SVH
`define SPD_REGS_SVH

// ============================================================
// Register map
`define SPD_ADDR_W 8
`define SPD_OUT_DATA_OFFSET 8'hAC
`define SPD_OUT_ENABLE_OFFSET 8'hB4

// ============================================================
// Fields and reset values
`define SPD_PIN_COUNT 12
`define SPD_PINS_PER_PORT 4
`define SPD_DATA_W 32
`define SPD_OUT_DATA_RESET 12'h000
`define SPD_OUT_ENABLE_RESET 12'h000
`define SPD_FIELD_CLOCK 0
`define SPD_FIELD_MASTER_IN 1
`define SPD_FIELD_MASTER_OUT 2
`define SPD_FIELD_SELECT 3

`endif

// ### rtl/spd_pkg.sv
// Purpose: Types shared by the serial port pin data block
// Assumes: Nothing beyond the register header
// Notes: Types only
package spd_pkg;
    typedef enum logic [1:0] {
        SPD_PORT_A,
        SPD_PORT_B,
        SPD_PORT_C
    } spd_port_type;

    typedef enum logic [1:0] {
        SPD_SEL_NONE,
        SPD_SEL_DATA,
        SPD_SEL_ENABLE
    } spd_sel_type;
endpackage

// ### rtl/spd_reg_decode.sv
// Purpose: Address decode and read mux for the pin data registers
// Assumes: Plain port, read data one cycle after the read strobe
// Notes: Unmapped addresses read zero and drop writes
`timescale 1ns/1ps
`include "spd_regs.svh"

module spd_reg_decode #(
    parameter int PIN_COUNT = `SPD_PIN_COUNT
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // Bus side
    input wire logic [`SPD_ADDR_W-1:0] addr,
    input wire logic rd_stb,
    output logic [`SPD_DATA_W-1:0] rd_data,
    // Register values
    input wire logic [PIN_COUNT-1:0] data_value,
    input wire logic [PIN_COUNT-1:0] enable_value,
    output spd_pkg::spd_sel_type sel
);
    function automatic spd_pkg::spd_sel_type decode(input logic [`SPD_ADDR_W-1:0] a);
        case (a)
            `SPD_OUT_DATA_OFFSET: decode = spd_pkg::SPD_SEL_DATA;
            `SPD_OUT_ENABLE_OFFSET: decode = spd_pkg::SPD_SEL_ENABLE;
            default: decode = spd_pkg::SPD_SEL_NONE;
        endcase
    endfunction

    assign sel = decode(addr);

    // ============================================================
    // Registered read data, upper bits zero
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            rd_data <= 32'h0000_0000;
        end else if (rd_stb) begin
            case (sel)
                spd_pkg::SPD_SEL_DATA:
                    rd_data <= {{(`SPD_DATA_W-PIN_COUNT){1'b0}}, data_value};
                spd_pkg::SPD_SEL_ENABLE:
                    rd_data <= {{(`SPD_DATA_W-PIN_COUNT){1'b0}}, enable_value};
                default: rd_data <= 32'h0000_0000;
            endcase
        end else begin
            rd_data <= 32'h0000_0000;
        end
    end
endmodule

// ### rtl/spd_pin_mux.sv
// Purpose: Per-pin output drive from the data and enable bits
// Assumes: Functional drive comes from the owning peripheral
// Notes: Combinational only
`timescale 1ns/1ps
`include "spd_regs.svh"

module spd_pin_mux #(
    parameter int PIN_COUNT = `SPD_PIN_COUNT
) (
    // Register values
    input wire logic [PIN_COUNT-1:0] data_value,
    input wire logic [PIN_COUNT-1:0] enable_value,
    // Peripheral side
    input wire logic [PIN_COUNT-1:0] func_out,
    input wire logic [PIN_COUNT-1:0] func_oe,
    // Pin side
    output logic [PIN_COUNT-1:0] pin_out,
    output logic [PIN_COUNT-1:0] pin_oe
);
    genvar i;
    generate
        for (i = 0; i < PIN_COUNT; i++) begin : g_pin
            assign pin_out[i] = enable_value[i] ? data_value[i] : func_out[i];
            assign pin_oe[i] = enable_value[i] | func_oe[i];
        end
    endgenerate
endmodule

// ### rtl/spd_top.sv
// Behaviour
// - Bits 0 to 3 hold port A clock, master-in, master-out and select output values.
// - Bits 4 to 7 hold port B clock, master-in, master-out and select output values.
// - Bit 8 holds port C clock, with its master-in, master-out and select above it.
// - A pin enabled as general output is driven to its stored data bit.
// - A pin not enabled as general output ignores its data bit, which still stores.
// - Every pin data bit is read and written by software and resets to zero.
//
// Purpose: General output data register for the three serial port pin groups
// Assumes: Enable register here stands in for the pin-function selection
// Notes: Pin vector order is clock, master-in, master-out, select per port
`timescale 1ns/1ps
`include "spd_regs.svh"

module spd_top #(
    parameter int PIN_COUNT = `SPD_PIN_COUNT
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // Register port
    input wire logic [`SPD_ADDR_W-1:0] addr,
    input wire logic [`SPD_DATA_W-1:0] wr_data,
    input wire logic wr_stb,
    input wire logic rd_stb,
    output logic [`SPD_DATA_W-1:0] rd_data,
    // Peripheral functional drive
    input wire logic [PIN_COUNT-1:0] func_out,
    input wire logic [PIN_COUNT-1:0] func_oe,
    // Pins
    output logic [PIN_COUNT-1:0] pin_out,
    output logic [PIN_COUNT-1:0] pin_oe
);
    // Refuse pin counts the field map cannot serve
    if (PIN_COUNT != `SPD_PIN_COUNT) begin : g_bad_pin_count
        $error("PIN_COUNT must be 12");
    end

    // ============================================================
    // Registers
    logic [PIN_COUNT-1:0] out_data;
    logic [PIN_COUNT-1:0] out_enable;
    spd_pkg::spd_sel_type sel;
    logic data_wr;
    logic enable_wr;
    logic data_rd;
    logic enable_rd;
    logic none_wr;
    logic none_rd;

    // Access qualifiers shared by registers and checks
    assign data_wr = wr_stb && sel == spd_pkg::SPD_SEL_DATA;
    assign enable_wr = wr_stb && sel == spd_pkg::SPD_SEL_ENABLE;
    assign data_rd = rd_stb && sel == spd_pkg::SPD_SEL_DATA;
    assign enable_rd = rd_stb && sel == spd_pkg::SPD_SEL_ENABLE;
    assign none_wr = wr_stb && sel == spd_pkg::SPD_SEL_NONE;
    assign none_rd = rd_stb && sel == spd_pkg::SPD_SEL_NONE;

    spd_reg_decode #(.PIN_COUNT(PIN_COUNT)) u_decode (
        .sys_clk(sys_clk),
        .rst(rst),
        .addr(addr),
        .rd_stb(rd_stb),
        .rd_data(rd_data),
        .data_value(out_data),
        .enable_value(out_enable),
        .sel(sel)
    );

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            out_data <= `SPD_OUT_DATA_RESET;
        end else if (data_wr) begin
            out_data <= wr_data[PIN_COUNT-1:0];
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            out_enable <= `SPD_OUT_ENABLE_RESET;
        end else if (enable_wr) begin
            out_enable <= wr_data[PIN_COUNT-1:0];
        end
    end

    // ============================================================
    // Pin drive
    // enable selects data
    spd_pin_mux #(.PIN_COUNT(PIN_COUNT)) u_mux (
        .data_value(out_data),
        .enable_value(out_enable),
        .func_out(func_out),
        .func_oe(func_oe),
        .pin_out(pin_out),
        .pin_oe(pin_oe)
    );

    // ============================================================
    // Checks
    // write then readback
    data_readback_a: assert property (@(posedge sys_clk) disable iff (rst)
        (wr_stb && sel == spd_pkg::SPD_SEL_DATA) ##1 (rd_stb && addr == `SPD_OUT_DATA_OFFSET)
        |=> rd_data[PIN_COUNT-1:0] == $past(wr_data[PIN_COUNT-1:0], 2))
        else $error("data readback mismatch");
    upper_zero_a: assert property (@(posedge sys_clk) disable iff (rst)
        rd_data[`SPD_DATA_W-1:PIN_COUNT] == '0)
        else $error("reserved bits not zero");
    enabled_drive_a: assert property (@(posedge sys_clk) disable iff (rst)
        (wr_stb && sel == spd_pkg::SPD_SEL_DATA && out_enable[0])
        |=> pin_out[0] == $past(wr_data[0]) && pin_oe[0])
        else $error("enabled pin not driven from data");
    disabled_pass_a: assert property (@(posedge sys_clk) disable iff (rst)
        !out_enable[`SPD_FIELD_SELECT] |-> pin_out[`SPD_FIELD_SELECT] == func_out[`SPD_FIELD_SELECT])
        else $error("disabled pin affected by data");
    port_c_clock_a: assert property (@(posedge sys_clk) disable iff (rst)
        (wr_stb && sel == spd_pkg::SPD_SEL_DATA) |=> out_data[8] == $past(wr_data[8]))
        else $error("port C clock bit not stored");
    port_b_select_a: assert property (@(posedge sys_clk) disable iff (rst)
        (wr_stb && sel == spd_pkg::SPD_SEL_DATA) |=> out_data[7] == $past(wr_data[7]))
        else $error("port B select bit not stored");
    port_a_clock_a: assert property (@(posedge sys_clk) disable iff (rst)
        (wr_stb && sel == spd_pkg::SPD_SEL_DATA) |=> out_data[0] == $past(wr_data[0]))
        else $error("port A clock bit not stored");
    data_hold_a: assert property (@(posedge sys_clk) disable iff (rst)
        !(wr_stb && sel == spd_pkg::SPD_SEL_DATA) |=> $stable(out_data))
        else $error("data changed without write");
    reset_zero_a: assert property (@(posedge sys_clk)
        $past(rst) && !rst |-> out_data == '0 && out_enable == '0 && rd_data == '0)
        else $error("registers not clear after reset");
    rd_idle_zero_a: assert property (@(posedge sys_clk) disable iff (rst)
        !rd_stb |=> rd_data == '0)
        else $error("read data not zero outside a read");
    unmapped_write_a: assert property (@(posedge sys_clk) disable iff (rst)
        none_wr |=> $stable(out_data) && $stable(out_enable))
        else $error("unmapped write changed a register");
    unmapped_read_a: assert property (@(posedge sys_clk) disable iff (rst)
        none_rd |=> rd_data == '0)
        else $error("unmapped read not zero");
    enable_read_a: assert property (@(posedge sys_clk) disable iff (rst)
        enable_rd |=> rd_data[PIN_COUNT-1:0] == $past(out_enable))
        else $error("enable readback mismatch");
    enable_store_a: assert property (@(posedge sys_clk) disable iff (rst)
        enable_wr |=> out_enable == $past(wr_data[PIN_COUNT-1:0]))
        else $error("enable write not stored");

    // ============================================================
    // Field placement per port
    genvar port_i;
    generate
        for (port_i = 0; port_i < PIN_COUNT / `SPD_PINS_PER_PORT; port_i++) begin : g_port_chk
            localparam int BASE = port_i * `SPD_PINS_PER_PORT;
            localparam int CLK_BIT = BASE + `SPD_FIELD_CLOCK;
            localparam int MI_BIT = BASE + `SPD_FIELD_MASTER_IN;
            localparam int MO_BIT = BASE + `SPD_FIELD_MASTER_OUT;
            localparam int SEL_BIT = BASE + `SPD_FIELD_SELECT;
            clock_store_a: assert property (@(posedge sys_clk) disable iff (rst)
                data_wr |=> out_data[CLK_BIT] == $past(wr_data[CLK_BIT]))
                else $error("clock field not stored at its bit");
            min_store_a: assert property (@(posedge sys_clk) disable iff (rst)
                data_wr |=> out_data[MI_BIT] == $past(wr_data[MI_BIT]))
                else $error("master-in field not stored at its bit");
            mout_store_a: assert property (@(posedge sys_clk) disable iff (rst)
                data_wr |=> out_data[MO_BIT] == $past(wr_data[MO_BIT]))
                else $error("master-out field not stored at its bit");
            select_store_a: assert property (@(posedge sys_clk) disable iff (rst)
                data_wr |=> out_data[SEL_BIT] == $past(wr_data[SEL_BIT]))
                else $error("select field not stored at its bit");
            clock_read_a: assert property (@(posedge sys_clk) disable iff (rst)
                data_rd |=> rd_data[CLK_BIT] == $past(out_data[CLK_BIT]))
                else $error("clock field not read at its bit");
            min_read_a: assert property (@(posedge sys_clk) disable iff (rst)
                data_rd |=> rd_data[MI_BIT] == $past(out_data[MI_BIT]))
                else $error("master-in field not read at its bit");
            mout_read_a: assert property (@(posedge sys_clk) disable iff (rst)
                data_rd |=> rd_data[MO_BIT] == $past(out_data[MO_BIT]))
                else $error("master-out field not read at its bit");
            select_read_a: assert property (@(posedge sys_clk) disable iff (rst)
                data_rd |=> rd_data[SEL_BIT] == $past(out_data[SEL_BIT]))
                else $error("select field not read at its bit");
        end
    endgenerate

    // ============================================================
    // Per-pin drive checks
    genvar pin_i;
    generate
        for (pin_i = 0; pin_i < PIN_COUNT; pin_i++) begin : g_pin_chk
            pin_drive_a: assert property (@(posedge sys_clk) disable iff (rst)
                out_enable[pin_i] |-> pin_out[pin_i] == out_data[pin_i] && pin_oe[pin_i])
                else $error("enabled pin not at its data level");
            pin_pass_a: assert property (@(posedge sys_clk) disable iff (rst)
                !out_enable[pin_i] |-> pin_out[pin_i] == func_out[pin_i]
                    && pin_oe[pin_i] == func_oe[pin_i])
                else $error("disabled pin affected by data");
            pin_store_a: assert property (@(posedge sys_clk) disable iff (rst)
                data_wr && !out_enable[pin_i] |=> out_data[pin_i] == $past(wr_data[pin_i]))
                else $error("disabled pin bit not stored");
            pin_read_a: assert property (@(posedge sys_clk) disable iff (rst)
                data_rd |=> rd_data[pin_i] == $past(out_data[pin_i]))
                else $error("pin bit not read back");
        end
    endgenerate

    data_write_c: cover property (@(posedge sys_clk) disable iff (rst)
        wr_stb && sel == spd_pkg::SPD_SEL_DATA);
    enable_write_c: cover property (@(posedge sys_clk) disable iff (rst)
        wr_stb && sel == spd_pkg::SPD_SEL_ENABLE);
    gpio_drive_c: cover property (@(posedge sys_clk) disable iff (rst)
        out_enable != '0 && out_data != '0);
    data_readback_c: cover property (@(posedge sys_clk) disable iff (rst)
        data_wr ##1 data_rd);
    mixed_pins_c: cover property (@(posedge sys_clk) disable iff (rst)
        out_enable != '0 && ~out_enable != '0);
endmodule

// ### verification/tb_serial_port_pin_gpio_output_data.sv
// Purpose: Self-checking bench for the serial port pin output data block
// Assumes: Data at the data offset, enable register as pin-function stand-in
// Notes: Read results checked from a queue of expected words
`timescale 1ns/1ps
`include "spd_regs.svh"

module tb_serial_port_pin_gpio_output_data;
    // ============================================================
    // Stimulus and observed signals
    logic sys_clk;
    logic rst;
    logic [`SPD_ADDR_W-1:0] addr;
    logic [`SPD_DATA_W-1:0] wr_data;
    logic wr_stb;
    logic rd_stb;
    logic [`SPD_DATA_W-1:0] rd_data;
    logic [11:0] func_out;
    logic [11:0] func_oe;
    logic [11:0] pin_out;
    logic [11:0] pin_oe;
    logic [31:0] exp_q[$];
    logic rd_due;
    int failures;
    int compares;
    int cycles;
    logic [31:0] seed;
    logic [31:0] d;
    logic [31:0] e;
    logic [31:0] r;

    spd_top dut (
        .sys_clk(sys_clk), .rst(rst), .addr(addr), .wr_data(wr_data), .wr_stb(wr_stb),
        .rd_stb(rd_stb), .rd_data(rd_data), .func_out(func_out), .func_oe(func_oe),
        .pin_out(pin_out), .pin_oe(pin_oe)
    );

    initial begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end

    // ============================================================
    // Shared tasks
    task check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            failures++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task bus(input logic rd, input logic [7:0] a, input logic [31:0] dat);
        @(posedge sys_clk);
        rd_stb <= rd;
        wr_stb <= !rd;
        addr <= a;
        wr_data <= dat;
    endtask

    task rd(input logic [7:0] a, input logic [31:0] exp);
        exp_q.push_back(exp);
        bus(1'b1, a, 32'h0000_0000);
    endtask

    task idle_pins(input logic [11:0] exp_out, input logic [11:0] exp_oe);
        @(posedge sys_clk);
        rd_stb <= 1'b0;
        wr_stb <= 1'b0;
        @(negedge sys_clk);
        check({20'h0, pin_out}, {20'h0, exp_out});
        check({20'h0, pin_oe}, {20'h0, exp_oe});
    endtask

    task test_done;
        if (failures == 0 && compares > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // ============================================================
    // Read result monitor
    always @(posedge sys_clk) rd_due <= rd_stb;

    always @(negedge sys_clk) begin
        if (rd_due && exp_q.size() > 0) begin
            check(rd_data, exp_q.pop_front());
        end else if (!rd_due) begin
            check(rd_data, 32'h0000_0000);
        end
    end

    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 3000) begin
            failures++;
            test_done;
        end
    end

    // ============================================================
    // Main sequence
    initial begin
        seed = 32'hC6A450D1;
        rst <= 1'b1;
        addr <= 8'h00;
        wr_data <= 32'h0000_0000;
        wr_stb <= 1'b0;
        rd_stb <= 1'b0;
        func_out <= 12'hA5C;
        func_oe <= 12'h3C6;
        repeat (20) @(posedge sys_clk);
        rst <= 1'b0;
        rd(`SPD_OUT_DATA_OFFSET, 32'h0000_0000);
        rd(`SPD_OUT_ENABLE_OFFSET, 32'h0000_0000);
        idle_pins(12'hA5C, 12'h3C6);
        bus(1'b0, `SPD_OUT_ENABLE_OFFSET, 32'hFFFF_FFFF);
        // Walking one over every pin position
        for (int i = 0; i < 12; i++) begin
            bus(1'b0, `SPD_OUT_DATA_OFFSET, 32'h1 << i);
            rd(`SPD_OUT_DATA_OFFSET, 32'h1 << i);
            idle_pins(12'h1 << i, 12'hFFF);
        end
        // Random data, enables and peripheral drive
        for (int i = 0; i < 24; i++) begin
            d = $random(seed);
            e = $random(seed);
            bus(1'b0, `SPD_OUT_ENABLE_OFFSET, e);
            r = $random(seed);
            func_out <= r[11:0];
            r = $random(seed);
            func_oe <= r[11:0];
            bus(1'b0, `SPD_OUT_DATA_OFFSET, d);
            rd(`SPD_OUT_DATA_OFFSET, {20'h0, d[11:0]});
            rd(`SPD_OUT_ENABLE_OFFSET, {20'h0, e[11:0]});
            idle_pins((e[11:0] & d[11:0]) | (~e[11:0] & func_out), e[11:0] | func_oe);
        end
        // Unmapped place drops writes and reads zero
        bus(1'b0, 8'h40, 32'hFFFF_FFFF);
        rd(8'h40, 32'h0000_0000);
        rd(`SPD_OUT_DATA_OFFSET, {20'h0, d[11:0]});
        idle_pins((e[11:0] & d[11:0]) | (~e[11:0] & func_out), e[11:0] | func_oe);
        // Reset in mid-run clears both registers
        @(posedge sys_clk);
        rst <= 1'b1;
        repeat (2) @(posedge sys_clk);
        rst <= 1'b0;
        rd(`SPD_OUT_DATA_OFFSET, 32'h0000_0000);
        rd(`SPD_OUT_ENABLE_OFFSET, 32'h0000_0000);
        idle_pins(func_out, func_oe);
        repeat (2) @(posedge sys_clk);
        test_done;
    end
endmodule
